// ===== hdl/scrp_port.sv
// Two-wire client port giving a host byte access to the register map
// Operation
// - Start is data falling while clock high; it begins a transaction.
// - First byte is 7-bit address then direction bit, 1 means host reads.
// - Respond to client address 57h in the standard variant.
// - Bytes are eight bits, most significant bit first, both directions.
// - Acknowledge each received byte by pulling data low in ninth clock; a data byte is NACKed while the write FIFO is full.
// - Stop, data rising while clock high, resets the client state machine.
// - Never stretch the clock; tolerate host stretching.
// - With time-out enabled, reset logic if clock stays low over 30 ms.
// - With time-out enabled and awake, reset if bus idles high over 200 us.
// - Time-out and idle reset disabled after reset until software enables.
// - After a time-out, resume on the next start condition.
// - Operate correctly with clock rates up to 400 kHz.
// - Write Byte stores one data byte at the addressed register.
// - Read Byte: address written, repeated start, one byte returned.
// - Block Write stores successive bytes at contiguous registers.
// - Pointer increments when the acknowledge for a written byte is driven.
// - Pointer is unchecked and wraps from FFh to 00h.
// - Accept Send Byte, Read Byte, Block Read and Receive Byte as well.
// - Block Read returns contiguous registers until the host NACKs.
// - Send Byte loads pointer; a second back-to-back Send Byte is NACKed.
// - Receive Byte returns the register at the pointer without addressing.
`timescale 1ns/1ns
module scrp_port #(
  parameter logic [6:0] OWN_ADDR = scrp_pkg::CLIENT_ADDR,
  parameter int TIMEOUT_CYCLES = scrp_pkg::TIMEOUT_CYCLES,
  parameter int IDLE_CYCLES = scrp_pkg::IDLE_CYCLES,
  parameter int FIFO_DEPTH = scrp_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic serial_clock_pin,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic timeout_disable,
  input wire logic sleep,
  output logic [7:0] reg_wr_addr,
  output logic [7:0] reg_wr_data,
  output logic reg_wr_valid,
  input wire logic reg_wr_ready,
  output logic [7:0] reg_rd_addr,
  input wire logic [7:0] reg_rd_data,
  output logic [7:0] reg_pointer,
  output logic bus_reset
);
  initial begin
    if (TIMEOUT_CYCLES < 1 || IDLE_CYCLES < 1) begin
      $error("scrp_port time-out counts must be at least one cycle");
    end
    // Each clock half at 400 kHz must span several samples after syncing
    if (scrp_pkg::CLK_HZ / (scrp_pkg::MAX_SCL_KHZ * 1000) < 16) begin
      $error("scrp_port system clock too slow for the serial clock");
    end
  end

  localparam int TW = $clog2(TIMEOUT_CYCLES + 1);
  localparam int IW = $clog2(IDLE_CYCLES + 1);

  logic rst_meta;
  logic rst_q_n;
  logic scl_s;
  logic sda_s;
  logic scl_d;
  logic sda_d;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic [TW-1:0] low_cnt;
  logic [IW-1:0] idle_cnt;
  logic timeout_hit;
  scrp_pkg::scrp_state_t state;
  logic [2:0] bit_cnt;
  logic [7:0] shift;
  logic is_read;
  logic have_ptr;
  logic sent_ptr_only;
  logic byte_in_txn;
  // Set by the first address bit, so the clock fall closing a start is not read as a byte end
  logic addr_armed;
  logic ack_ok;
  logic [7:0] tx_byte;
  logic [7:0] ptr;
  scrp_pkg::scrp_wr_t wr_cmd;
  logic wr_push;
  logic fifo_in_ready;
  scrp_pkg::scrp_wr_t fifo_out;

  // Reset release through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta <= 1'b0;
      rst_q_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_q_n <= rst_meta;
    end
  end

  scrp_sync #(.INIT(1'b1)) u_scl_sync (
    .clk(clk),
    .rst_n(rst_q_n),
    .din(serial_clock_pin),
    .dout(scl_s)
  );

  scrp_sync #(.INIT(1'b1)) u_sda_sync (
    .clk(clk),
    .rst_n(rst_q_n),
    .din(sda_in),
    .dout(sda_s)
  );

  always_ff @(posedge clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;
  assign start_det = scl_s && scl_d && sda_d && !sda_s;
  assign stop_det = scl_s && scl_d && !sda_d && sda_s;

  // Clock-low time-out and idle watch; off while the disable bit is set
  always_ff @(posedge clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      low_cnt <= '0;
      idle_cnt <= '0;
    end else begin
      if (timeout_disable || scl_s || timeout_hit) begin
        low_cnt <= '0;
      end else if (low_cnt != TW'(TIMEOUT_CYCLES)) begin
        low_cnt <= low_cnt + 1'b1;
      end
      if (timeout_disable || sleep || !scl_s || !sda_s || timeout_hit) begin
        idle_cnt <= '0;
      end else if (idle_cnt != IW'(IDLE_CYCLES)) begin
        idle_cnt <= idle_cnt + 1'b1;
      end
    end
  end

  // Only reset an active transaction; idle bus needs no action
  assign timeout_hit = (state != scrp_pkg::ST_IDLE) &&
                       ((low_cnt == TW'(TIMEOUT_CYCLES)) ||
                        (idle_cnt == IW'(IDLE_CYCLES)));

  always_ff @(posedge clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      bus_reset <= 1'b0;
    end else begin
      bus_reset <= timeout_hit || (stop_det && state != scrp_pkg::ST_IDLE);
    end
  end

  assign ack_ok = !sda_s;

  // Protocol engine; samples data on clock rise, changes data on clock fall.
  // The clock pin is never driven, so the host may stretch freely
  always_ff @(posedge clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      state <= scrp_pkg::ST_IDLE;
      bit_cnt <= '0;
      shift <= '0;
      is_read <= 1'b0;
      byte_in_txn <= 1'b0;
      addr_armed <= 1'b0;
    end else if (start_det) begin
      state <= scrp_pkg::ST_ADDR;
      bit_cnt <= '0;
      byte_in_txn <= 1'b0;
      addr_armed <= 1'b0;
    end else if (stop_det || timeout_hit) begin
      state <= scrp_pkg::ST_IDLE;
    end else begin
      case (state)
        scrp_pkg::ST_ADDR: begin
          if (scl_rise) begin
            shift <= {shift[6:0], sda_s};
            bit_cnt <= bit_cnt + 1'b1;
            addr_armed <= 1'b1;
          end else if (scl_fall && bit_cnt == 3'd0 && addr_armed) begin
            is_read <= shift[0];
            if (shift[7:1] == OWN_ADDR) begin
              state <= scrp_pkg::ST_ADDR_ACK;
            end else begin
              state <= scrp_pkg::ST_IGNORE;
            end
          end
        end
        scrp_pkg::ST_ADDR_ACK: begin
          if (scl_fall) begin
            state <= is_read ? scrp_pkg::ST_TX : scrp_pkg::ST_RX;
          end
        end
        scrp_pkg::ST_RX: begin
          if (scl_rise) begin
            shift <= {shift[6:0], sda_s};
            bit_cnt <= bit_cnt + 1'b1;
          end else if (scl_fall && bit_cnt == 3'd0) begin
            state <= scrp_pkg::ST_RX_ACK;
          end
        end
        scrp_pkg::ST_RX_ACK: begin
          if (scl_fall) begin
            byte_in_txn <= 1'b1;
            state <= scrp_pkg::ST_RX;
          end
        end
        scrp_pkg::ST_TX: begin
          if (scl_fall) begin
            bit_cnt <= bit_cnt + 1'b1;
            if (bit_cnt == 3'd7) begin
              state <= scrp_pkg::ST_TX_ACK;
            end
          end
        end
        scrp_pkg::ST_TX_ACK: begin
          if (scl_rise && !ack_ok) begin
            state <= scrp_pkg::ST_IGNORE;
          end else if (scl_fall) begin
            state <= scrp_pkg::ST_TX;
          end
        end
        scrp_pkg::ST_IGNORE: begin
          state <= scrp_pkg::ST_IGNORE;
        end
        default: begin
          state <= scrp_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // The second of two Send Byte transactions in a row gets no acknowledge
  logic nack_ptr;
  assign nack_ptr = sent_ptr_only && !byte_in_txn;

  // Pointer and Send Byte tracking
  always_ff @(posedge clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      ptr <= scrp_pkg::PTR_RESET;
      have_ptr <= 1'b0;
      sent_ptr_only <= 1'b0;
    end else begin
      if (start_det) begin
        have_ptr <= 1'b0;
      end
      if (state == scrp_pkg::ST_RX && scl_fall && bit_cnt == 3'd0 && !have_ptr && !nack_ptr) begin
        ptr <= shift;
        have_ptr <= 1'b1;
      end
      // Increment as the data acknowledge is driven
      if (state == scrp_pkg::ST_RX && scl_fall && bit_cnt == 3'd0 && have_ptr && fifo_in_ready) begin
        ptr <= ptr + 8'h01;
      end
      // Advance after each transmitted byte
      if (state == scrp_pkg::ST_TX && scl_fall && bit_cnt == 3'd7) begin
        ptr <= ptr + 8'h01;
      end
      // Pointer byte acknowledge marks a Send Byte; a later data byte's acknowledge or a read clears it.
      // The stop's own clock rise must not clear it, so nothing here looks at clock rises
      if (state == scrp_pkg::ST_RX_ACK && scl_fall) begin
        sent_ptr_only <= !byte_in_txn && !nack_ptr;
      end
      if (state == scrp_pkg::ST_ADDR_ACK && is_read) begin
        sent_ptr_only <= 1'b0;
      end
    end
  end

  // Data byte written to the register map through the FIFO
  assign wr_push = state == scrp_pkg::ST_RX && scl_fall && bit_cnt == 3'd0 && have_ptr;
  assign wr_cmd.addr = ptr;
  assign wr_cmd.data = shift;

  scrp_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst_n(rst_q_n),
    .in_data(wr_cmd),
    .in_valid(wr_push),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(reg_wr_valid),
    .out_ready(reg_wr_ready)
  );

  assign reg_wr_addr = fifo_out.addr;
  assign reg_wr_data = fifo_out.data;

  // Transmit byte captured on the acknowledge clock rise before each read byte
  always_ff @(posedge clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      tx_byte <= '0;
    end else if ((state == scrp_pkg::ST_ADDR_ACK || state == scrp_pkg::ST_TX_ACK) && scl_rise) begin
      tx_byte <= reg_rd_data;
    end else if (state == scrp_pkg::ST_TX && scl_fall) begin
      tx_byte <= {tx_byte[6:0], 1'b0};
    end
  end

  always_ff @(posedge clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      reg_rd_addr <= scrp_pkg::PTR_RESET;
      reg_pointer <= scrp_pkg::PTR_RESET;
    end else begin
      reg_rd_addr <= ptr;
      reg_pointer <= ptr;
    end
  end

  // Data drive: low for acknowledge, data bits while transmitting, else released
  always_ff @(posedge clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      sda_oe <= 1'b0;
    end else if (start_det || stop_det || timeout_hit) begin
      sda_oe <= 1'b0;
    end else if (scl_fall) begin
      if (state == scrp_pkg::ST_ADDR && bit_cnt == 3'd0 && addr_armed && shift[7:1] == OWN_ADDR) begin
        sda_oe <= 1'b1;
      end else if (state == scrp_pkg::ST_RX && bit_cnt == 3'd0) begin
        sda_oe <= !nack_ptr && (!have_ptr || fifo_in_ready);
      end else if (state == scrp_pkg::ST_ADDR_ACK && is_read) begin
        sda_oe <= !reg_rd_data[7];
      end else if (state == scrp_pkg::ST_TX && bit_cnt != 3'd7) begin
        sda_oe <= !tx_byte[6];
      end else if (state == scrp_pkg::ST_TX_ACK && ack_ok) begin
        sda_oe <= !tx_byte[7];
      end else begin
        sda_oe <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end
endmodule : scrp_port

// ===== common/scrp_pkg.sv
// Shared constants and carrier types for the serial register port
package scrp_pkg;
  localparam logic [6:0] CLIENT_ADDR = 7'h57;
  localparam int BYTE_BITS = 8;
  localparam int CLK_HZ = 100_000_000;
  localparam int TIMEOUT_MS = 30;
  localparam int IDLE_US = 200;
  localparam int MAX_SCL_KHZ = 400;
  // Longest low time rounds down; idle time rounds down as well
  localparam int TIMEOUT_CYCLES = TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int IDLE_CYCLES = IDLE_US * (CLK_HZ / 1_000_000);
  localparam int FIFO_DEPTH = 8;
  localparam logic [7:0] PTR_RESET = 8'h00;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } scrp_wr_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ADDR_ACK = 3'b011,
    ST_RX = 3'b010,
    ST_RX_ACK = 3'b110,
    ST_TX = 3'b111,
    ST_TX_ACK = 3'b101,
    ST_IGNORE = 3'b100
  } scrp_state_t;
endpackage : scrp_pkg

// ===== hdl/scrp_sync.sv
// Two-flop synchroniser for one level from outside the clock domain
`timescale 1ns/1ns
module scrp_sync #(
  parameter logic INIT = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic din,
  output logic dout
);
  logic meta;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= INIT;
      dout <= INIT;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule : scrp_sync

// ===== hdl/scrp_fifo.sv
// Small synchronous FIFO for register write commands
`timescale 1ns/1ns
module scrp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("scrp_fifo depth must be a power of two of at least 2");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic full;
  logic empty;
  logic push;
  logic pop;

  assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty = (wr_ptr == rd_ptr);
  assign push = in_valid && !full;
  assign pop = out_valid && out_ready;
  assign in_ready = !full;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
    end else if (push) begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end

  // Output is registered; a word is presented only after it left memory
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_ptr <= '0;
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (!out_valid || pop) begin
      if (!empty) begin
        out_data <= mem[rd_ptr[AW-1:0]];
        out_valid <= 1'b1;
        rd_ptr <= rd_ptr + 1'b1;
      end else begin
        out_valid <= 1'b0;
      end
    end
  end
endmodule : scrp_fifo

// ===== verification/scrp_port_sva.sv
// Concurrent checks on the serial register port pins
`timescale 1ns/1ns
module scrp_port_sva #(
  parameter int TIMEOUT_CYCLES = 3000
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic serial_clock_pin,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic timeout_disable,
  input wire logic [7:0] reg_wr_addr,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_wr_valid,
  input wire logic reg_wr_ready,
  input wire logic [7:0] reg_rd_addr,
  input wire logic [7:0] reg_pointer,
  input wire logic bus_reset
);
  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  int lo_cnt;
  // Counts only while armed, so a disabled time-out never reaches the mark
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lo_cnt <= 0;
    end else if (!serial_clock_pin && !timeout_disable) begin
      lo_cnt <= lo_cnt + 1;
    end else begin
      lo_cnt <= 0;
    end
  end
  property p_open_drain;
    !sda_out;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("data pin driven high");
  property p_hold_high;
    serial_clock_pin && $past(serial_clock_pin) |-> $stable(sda_oe);
  endproperty
  a_hold_high: assert property (p_hold_high) else $error("data moved while clock high");
  property p_ack_len;
    $rose(sda_oe) |-> sda_oe [*8];
  endproperty
  a_ack_len: assert property (p_ack_len) else $error("pull-down too short");
  property p_wr_hold;
    reg_wr_valid && !reg_wr_ready |=> reg_wr_valid && $stable(reg_wr_addr) && $stable(reg_wr_data);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write word dropped");
  property p_reset_pulse;
    bus_reset |=> !bus_reset;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse) else $error("reset pulse too long");
  property p_reset_disabled;
    bus_reset && timeout_disable |-> serial_clock_pin;
  endproperty
  a_reset_disabled: assert property (p_reset_disabled) else $error("time-out while disabled");
  property p_timeout;
    lo_cnt == TIMEOUT_CYCLES + 16 |-> !sda_oe;
  endproperty
  a_timeout: assert property (p_timeout) else $error("no release after clock-low time-out");
  property p_rd_copy;
    $changed(reg_pointer) |-> !serial_clock_pin && reg_rd_addr == reg_pointer;
  endproperty
  a_rd_copy: assert property (p_rd_copy) else $error("read address differs from pointer");
endmodule : scrp_port_sva

bind scrp_port scrp_port_sva #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_sva (
  .clk(clk), .rst_n(rst_n), .serial_clock_pin(serial_clock_pin), .sda_out(sda_out),
  .sda_oe(sda_oe), .timeout_disable(timeout_disable), .reg_wr_addr(reg_wr_addr),
  .reg_wr_data(reg_wr_data), .reg_wr_valid(reg_wr_valid), .reg_wr_ready(reg_wr_ready),
  .reg_rd_addr(reg_rd_addr), .reg_pointer(reg_pointer), .bus_reset(bus_reset)
);

// ===== verification/scrp_host.sv
// Behavioural two-wire host driving the bus clock and data pull-down
`timescale 1ns/1ns
module scrp_host (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Quarter of the 160 ns bus clock period
  task automatic q();
    repeat (4) @(negedge clk);
  endtask : q
  // Data moves mid-low so it never races the clock edge in the synchronisers
  task automatic bitx(input logic b, input int s, output logic r);
    repeat (s) @(negedge clk);
    q();
    sda_low = !b;
    q();
    scl = 1'b1;
    q();
    q();
    r = sda;
    scl = 1'b0;
  endtask : bitx
  task automatic start();
    sda_low = 1'b0;
    q();
    q();
    scl = 1'b1;
    q();
    q();
    sda_low = 1'b1;
    q();
    q();
    scl = 1'b0;
  endtask : start
  task automatic stop();
    q();
    sda_low = 1'b1;
    q();
    scl = 1'b1;
    q();
    q();
    sda_low = 1'b0;
    q();
    q();
  endtask : stop
  task automatic idle(input int n);
    q();
    q();
    scl = 1'b1;
    repeat (n) @(negedge clk);
  endtask : idle
  // No byte-count prefix is ever sent
  task automatic wbyte(input logic [7:0] d, input int s, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], 0, r);
    bitx(1'b1, s, r);
    ack = !r;
  endtask : wbyte
  task automatic rbyte(input logic nack, input int s, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, 0, d[i]);
    bitx(nack, s, r);
  endtask : rbyte
endmodule : scrp_host

// ===== verification/scrp_port_bench.sv
// Self-checking bench for the serial register port
`timescale 1ns/1ns
module scrp_port_bench;
  localparam int TO = 2000;
  localparam logic [6:0] ME = scrp_pkg::CLIENT_ADDR;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic timeout_disable = 1'b1;
  logic reg_wr_ready = 1'b1;
  logic sleep = 1'b0;
  logic sda_oe, sda_out, reg_wr_valid, bus_reset, scl, host_low, sda, ack;
  logic [7:0] reg_wr_addr, reg_wr_data, reg_rd_addr, reg_rd_data, reg_pointer, d;
  logic [7:0] mem [256];
  int failures = 0, num_checks = 0, resets = 0, cyc = 0, n;
  // Pull-up on the data line; either party may pull it low
  assign sda = !(host_low || sda_oe);
  assign reg_rd_data = mem[reg_rd_addr];
  always #5 clk = ~clk;
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i * 3 + 1);
  always @(posedge clk) begin
    cyc++;
    if (reg_wr_valid === 1'b1 && reg_wr_ready) mem[reg_wr_addr] <= reg_wr_data;
    if (bus_reset === 1'b1) resets++;
    if (cyc == 40000) begin
      failures++;
      end_of_test();
    end
  end
  scrp_port #(.TIMEOUT_CYCLES(TO), .IDLE_CYCLES(200)) DUT (
    .clk(clk), .rst_n(rst_n), .serial_clock_pin(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .timeout_disable(timeout_disable), .sleep(sleep), .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data),
    .reg_wr_valid(reg_wr_valid), .reg_wr_ready(reg_wr_ready), .reg_rd_addr(reg_rd_addr),
    .reg_rd_data(reg_rd_data), .reg_pointer(reg_pointer), .bus_reset(bus_reset));
  scrp_host host (.clk(clk), .sda(sda), .scl(scl), .sda_low(host_low));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_ack(input logic exp);
    num_checks++;
    if (ack !== exp) begin
      failures++;
      $display("FAIL %0t ack %b expected %b", $time, ack, exp);
    end
  endtask : chk_ack
  task automatic hdr(input logic [6:0] a, input logic rd, input int s);
    host.start();
    host.wbyte({a, rd}, s, ack);
  endtask : hdr
  task automatic end_of_test();
    if (failures == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test
  // Register side stalls so the buffer fills and refuses
  task automatic t_block_write();
    reg_wr_ready = 1'b0;
    hdr(ME, 1'b0, 0);
    chk_ack(1'b1);
    host.wbyte(8'hFC, 0, ack);
    chk_ack(1'b1);
    n = 0;
    for (int i = 0; i < 10; i++) begin
      host.wbyte(8'(8'h30 + i), 0, ack);
      chk_ack(i < 9);
      n += ack;
    end
    chk(reg_pointer, 8'(252 + n));
    host.stop();
    for (int k = 0; k < 100 && reg_wr_valid !== 1'b0; k++) begin
      @(negedge clk);
      reg_wr_ready = ~reg_wr_ready;
    end
    reg_wr_ready = 1'b1;
    for (int k = 0; k < n; k++) chk(mem[8'(252 + k)], 8'(8'h30 + k));
  endtask : t_block_write
  task automatic t_block_read();
    hdr(ME, 1'b0, 0);
    host.wbyte(8'hFE, 0, ack);
    hdr(ME, 1'b1, 0);
    chk_ack(1'b1);
    for (int i = 0; i < 3; i++) begin
      host.rbyte(i == 2, 20, d);
      chk(d, mem[8'(254 + i)]);
    end
    host.stop();
    chk(reg_pointer, 8'h01);
    hdr(ME, 1'b1, 0);
    host.rbyte(1'b1, 0, d);
    host.stop();
    chk(d, mem[8'h01]);
  endtask : t_block_read
  task automatic t_send_twice();
    hdr(ME, 1'b0, 0);
    host.wbyte(8'h10, 0, ack);
    host.stop();
    hdr(ME, 1'b0, 0);
    host.wbyte(8'h20, 0, ack);
    chk_ack(1'b0);
    host.stop();
    hdr(ME, 1'b1, 0);
    host.rbyte(1'b1, 0, d);
    host.stop();
    chk(d, mem[8'h10]);
  endtask : t_send_twice
  task automatic t_wrong_addr();
    hdr(ME ^ 7'h01, 1'b0, 0);
    chk_ack(1'b0);
    host.wbyte(8'h00, 0, ack);
    chk_ack(1'b0);
    host.stop();
    chk(reg_pointer, 8'h11);
  endtask : t_wrong_addr
  task automatic t_timeouts();
    int r0;
    r0 = resets;
    hdr(ME, 1'b0, 0);
    host.wbyte(8'h05, 0, ack);
    host.wbyte(8'h66, TO + 300, ack);
    chk_ack(1'b1);
    chk(8'(resets), 8'(r0));
    host.stop();
    chk(8'(resets), 8'(r0 + 1));
    timeout_disable = 1'b0;
    hdr(ME, 1'b0, TO + 300);
    chk_ack(1'b0);
    chk(8'(resets), 8'(r0 + 2));
    hdr(ME, 1'b0, 0);
    host.wbyte(8'h07, 0, ack);
    sleep = 1'b1;
    host.idle(300);
    chk(8'(resets), 8'(r0 + 2));
    sleep = 1'b0;
    host.idle(300);
    chk(8'(resets), 8'(r0 + 3));
    hdr(ME, 1'b1, 0);
    chk_ack(1'b1);
    host.rbyte(1'b1, 0, d);
    host.stop();
    chk(d, mem[8'h07]);
    timeout_disable = 1'b1;
  endtask : t_timeouts
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    repeat (10) @(negedge clk);
    t_block_write();
    t_block_read();
    t_send_twice();
    t_wrong_addr();
    t_timeouts();
    end_of_test();
  end
endmodule : scrp_port_bench
